/* File: core/ffx_pkg.sv */
// ffx_pkg: constants, enums and carrier structs for the read-side flag and expansion block
// assumes a single system clock; write and read ports are enables on that clock
//
// Operation
// - half-full low when count exceeds half capacity
// - half-full async in compat, synced in enhanced when selected
// - write-expansion pulse when last location written
// - almost-empty low when count at/below offset
// - almost-empty offset resets to capacity/8 minus one
// - almost-empty async compat, read-synced when selected
// - empty low when no words; blocks reads
// - read-expansion pulse when last location read
// - enhanced mode: delayed empty copy, one cycle
// - half-full pin function fixed at reset by expansion inputs
// - read-expansion pin function fixed at reset by mode
// - 18-bit read data bus with three-state enable
package ffx_pkg;
  localparam int DATA_W = 18;
  localparam int ADDR_W = 10;
  localparam int CNT_W = ADDR_W + 1;
  localparam logic [CNT_W-1:0] DEPTH = 11'h400;
  localparam logic [CNT_W-1:0] HALF = 11'h200;
  localparam logic [CNT_W-1:0] AE_OFS_RST = 11'h07f;
  localparam logic [ADDR_W-1:0] LAST_ADDR = 10'h3ff;
  localparam logic [ADDR_W-1:0] ADDR_ZERO = 10'h000;
  localparam logic [ADDR_W-1:0] ADDR_ONE = 10'h001;
  localparam logic [CNT_W-1:0] CNT_ONE = 11'h001;
  localparam logic [CNT_W-1:0] CNT_ZERO = 11'h000;
  localparam int SYNC_STAGES = 3;

  // half-full flag timing selection in enhanced mode
  typedef enum logic [1:0] {
    FFX_HF_ASYNC = 2'b00,
    FFX_HF_WSYNC = 2'b01,
    FFX_HF_RSYNC = 2'b11
  } ffx_hfsel_e;

  // reset-time pin function snapshot
  typedef struct packed {
    logic enhanced;
    logic cascade;
  } ffx_cfg_s;

  // flag bundle, all active low
  typedef struct packed {
    logic empty_n;
    logic almost_empty_n;
    logic half_full_n;
  } ffx_flags_s;
endpackage

/* File: core/ffx_mem.sv */
// ffx_mem: storage array for the fifo, registered read data
// assumes write and read strobes are already qualified by the caller
`timescale 1ns/1ps
module ffx_mem
  import ffx_pkg::*;
(
  input  wire logic              clk_i,
  input  wire logic              we_i,
  input  wire logic [ADDR_W-1:0] waddr_i,
  input  wire logic [DATA_W-1:0] wdata_i,
  input  wire logic              re_i,
  input  wire logic [ADDR_W-1:0] raddr_i,
  output logic      [DATA_W-1:0] rdata_o
);
  logic [DATA_W-1:0] mem_reg [0:(1<<ADDR_W)-1]; // array, no reset so it maps to ram

  // write port and registered read port
  always_ff @(posedge clk_i) begin
    if (we_i) begin
      mem_reg[waddr_i] <= wdata_i;
    end
    if (re_i) begin
      rdata_o <= mem_reg[raddr_i];
    end
  end
endmodule

/* File: core/ffx_top.sv */
// ffx_top: fifo read-side flags, half-full, expansion pulses and output bus
// assumes strap pins are asynchronous and pass three flip-flops; enables are synchronous
`timescale 1ns/1ps
module ffx_top
  import ffx_pkg::*;
(
  // clock and reset
  input  wire logic              CLK_SYS_I,
  input  wire logic              SRST_I,
  // write side
  input  wire logic              WRITE_EN_I,
  input  wire logic [DATA_W-1:0] WRITE_DATA_I,
  // read side
  input  wire logic              READ_EN_I,
  input  wire logic              OUTPUT_EN_I,
  // straps and expansion inputs (pins)
  input  wire logic              ENHANCED_MODE_SELECT_N_I,
  input  wire logic              WRITE_EXPANSION_IN_I,
  input  wire logic              READ_EXPANSION_IN_I,
  // control bits
  input  wire logic [1:0]        HF_SYNC_SEL_I,
  input  wire logic              AE_SYNC_SEL_I,
  input  wire logic              AE_OFS_LOAD_I,
  input  wire logic [CNT_W-1:0]  AE_OFS_I,
  // flags
  output logic                   EMPTY_N_O,
  output logic                   ALMOST_EMPTY_N_O,
  output logic                   HALF_FULL_N_O,
  output logic                   FULL_N_O,
  // shared pins
  output logic                   WRITE_EXPANSION_OUT_O,
  output logic                   READ_EXPANSION_OUT_O,
  // read data bus
  output logic [DATA_W-1:0]      READ_DATA_BUS_O,
  output logic                   READ_DATA_BUS_OE_O,
  // status
  output logic [CNT_W-1:0]       OCCUPANCY_O
);
  // three-stage synchronisers for pins: mode, wxi, rxi
  logic [2:0] s1_reg, s2_reg, s3_reg;
  logic [2:0] pins_q; // filtered pin levels
  logic [2:0] pins_raw;
  assign pins_raw = {ENHANCED_MODE_SELECT_N_I, WRITE_EXPANSION_IN_I, READ_EXPANSION_IN_I};

  // synchroniser chain; the first stage feeds only the second
  always_ff @(posedge CLK_SYS_I) begin
    s1_reg <= pins_raw;
    s2_reg <= s1_reg;
    s3_reg <= s2_reg;
  end

  // a change counts once stages two and three agree
  // no reset here: the straps must be seen while reset is held, or the
  // pin function would always be captured from a cleared filter
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_filt
      always_ff @(posedge CLK_SYS_I) begin
        if (s2_reg[g] == s3_reg[g]) begin
          pins_q[g] <= s3_reg[g];
        end
      end
    end
  endgenerate

  logic mode_n_q, wxi_q, rxi_q;
  assign mode_n_q = pins_q[2];
  assign wxi_q    = pins_q[1];
  assign rxi_q    = pins_q[0];

  // pin function captured while reset is held; frozen after release
  ffx_cfg_s cfg_reg;
  ffx_cfg_s cfg_next;
  assign cfg_next.enhanced = ~mode_n_q;
  assign cfg_next.cascade  = (wxi_q | rxi_q) & mode_n_q;

  always_ff @(posedge CLK_SYS_I) begin
    if (SRST_I) begin
      cfg_reg <= cfg_next;
    end
  end

  // pointers and the single occupancy count
  logic [ADDR_W-1:0] wptr_reg, rptr_reg;
  logic [CNT_W-1:0]  cnt_reg, cnt_next;
  logic [CNT_W-1:0]  ae_ofs_reg;

  // qualified strobes: empty blocks reads, full blocks writes
  logic empty_w, full_w, wr_ok, rd_ok;
  assign empty_w = (cnt_reg == CNT_ZERO);
  assign full_w  = (cnt_reg == DEPTH);
  assign wr_ok   = WRITE_EN_I & ~full_w;
  assign rd_ok   = READ_EN_I & ~empty_w;

  // count moves up on writes, down on reads
  always_comb begin
    cnt_next = cnt_reg;
    if (wr_ok & ~rd_ok) begin
      cnt_next = cnt_reg + CNT_ONE;
    end else if (rd_ok & ~wr_ok) begin
      cnt_next = cnt_reg - CNT_ONE;
    end
  end

  // pointer and count state
  always_ff @(posedge CLK_SYS_I) begin
    if (SRST_I) begin
      wptr_reg <= ADDR_ZERO;
      rptr_reg <= ADDR_ZERO;
      cnt_reg  <= CNT_ZERO;
    end else begin
      cnt_reg <= cnt_next;
      if (wr_ok) begin
        wptr_reg <= wptr_reg + ADDR_ONE;
      end
      if (rd_ok) begin
        rptr_reg <= rptr_reg + ADDR_ONE;
      end
    end
  end

  // almost-empty offset: default on reset, loadable afterwards
  always_ff @(posedge CLK_SYS_I) begin
    if (SRST_I) begin
      ae_ofs_reg <= AE_OFS_RST;
    end else if (AE_OFS_LOAD_I) begin
      ae_ofs_reg <= AE_OFS_I;
    end
  end

  // raw flag levels straight from the count (the "asynchronous" path)
  ffx_flags_s raw_w;
  assign raw_w.empty_n        = ~empty_w;
  assign raw_w.almost_empty_n = ~(cnt_reg <= ae_ofs_reg);
  assign raw_w.half_full_n    = ~(cnt_reg > HALF);

  // registered copies model the clock-synchronised enhanced variants
  ffx_flags_s flags_reg;
  logic       empty_dly_reg; // empty delayed one clock cycle
  always_ff @(posedge CLK_SYS_I) begin
    if (SRST_I) begin
      flags_reg     <= 3'b001; // count zero: empty and almost-empty low, half-full high
      empty_dly_reg <= 1'b0;
    end else begin
      flags_reg     <= raw_w;
      empty_dly_reg <= EMPTY_N_O;
    end
  end

  // flag selection; on a single clock write- and read-sync coincide
  ffx_hfsel_e hf_sel;
  assign hf_sel = ffx_hfsel_e'(HF_SYNC_SEL_I);
  logic hf_sync_w, ae_sync_w;
  assign hf_sync_w = cfg_reg.enhanced & (hf_sel != FFX_HF_ASYNC);
  assign ae_sync_w = cfg_reg.enhanced & AE_SYNC_SEL_I;
  assign EMPTY_N_O = raw_w.empty_n;
  assign ALMOST_EMPTY_N_O = ae_sync_w ? flags_reg.almost_empty_n
                                      : raw_w.almost_empty_n;
  logic hf_level_w;
  assign hf_level_w = hf_sync_w ? flags_reg.half_full_n : raw_w.half_full_n;
  assign FULL_N_O = ~full_w;
  assign OCCUPANCY_O = cnt_reg;

  // expansion pulses: one cycle when the last location is touched
  logic wxo_reg, rxo_reg;
  always_ff @(posedge CLK_SYS_I) begin
    if (SRST_I) begin
      wxo_reg <= 1'b0;
      rxo_reg <= 1'b0;
    end else begin
      wxo_reg <= cfg_reg.cascade & wr_ok & (wptr_reg == LAST_ADDR);
      rxo_reg <= cfg_reg.cascade & rd_ok & (rptr_reg == LAST_ADDR);
    end
  end

  // shared pins; pulses active high, idle low
  assign WRITE_EXPANSION_OUT_O = cfg_reg.cascade ? wxo_reg : hf_level_w;
  assign HALF_FULL_N_O = hf_level_w;
  assign READ_EXPANSION_OUT_O = cfg_reg.enhanced ? empty_dly_reg : rxo_reg;

  // storage and data bus
  ffx_mem u_mem (
    .clk_i   (CLK_SYS_I),
    .we_i    (wr_ok),
    .waddr_i (wptr_reg),
    .wdata_i (WRITE_DATA_I),
    .re_i    (rd_ok),
    .raddr_i (rptr_reg),
    .rdata_o (READ_DATA_BUS_O)
  );
  assign READ_DATA_BUS_OE_O = OUTPUT_EN_I;

  // assertions
  a_empty_blocks_read: assert property (@(posedge CLK_SYS_I) disable iff (SRST_I)
    !EMPTY_N_O |=> $stable(rptr_reg)) else $error("read pointer moved while empty");
  a_dup_empty_delay: assert property (@(posedge CLK_SYS_I) disable iff (SRST_I)
    cfg_reg.enhanced |=> READ_EXPANSION_OUT_O == $past(EMPTY_N_O))
    else $error("delayed empty mismatch");
  a_half_full_level: assert property (@(posedge CLK_SYS_I) disable iff (SRST_I)
    !hf_sync_w |-> HALF_FULL_N_O == (cnt_reg <= HALF)) else $error("half-full wrong");
  a_ae_level: assert property (@(posedge CLK_SYS_I) disable iff (SRST_I)
    !ae_sync_w |-> ALMOST_EMPTY_N_O == (cnt_reg > ae_ofs_reg))
    else $error("almost-empty wrong");
  a_ae_sync_lag: assert property (@(posedge CLK_SYS_I) disable iff (SRST_I)
    ae_sync_w && $stable(ae_sync_w) |-> ALMOST_EMPTY_N_O == $past(raw_w.almost_empty_n))
    else $error("almost-empty sync lag");
  a_hf_sync_lag: assert property (@(posedge CLK_SYS_I) disable iff (SRST_I)
    hf_sync_w && $stable(hf_sync_w) |-> HALF_FULL_N_O == $past(raw_w.half_full_n))
    else $error("half-full sync lag");
  a_wxo_pulse: assert property (@(posedge CLK_SYS_I) disable iff (SRST_I)
    cfg_reg.cascade && wr_ok && wptr_reg == LAST_ADDR |=> WRITE_EXPANSION_OUT_O ##1
    !WRITE_EXPANSION_OUT_O) else $error("write expansion pulse wrong");
  a_rxo_pulse: assert property (@(posedge CLK_SYS_I) disable iff (SRST_I)
    cfg_reg.cascade && rd_ok && rptr_reg == LAST_ADDR |=> READ_EXPANSION_OUT_O)
    else $error("read expansion pulse missing");
  a_ofs_default: assert property (@(posedge CLK_SYS_I)
    $fell(SRST_I) |-> ae_ofs_reg == AE_OFS_RST) else $error("offset default wrong");
  a_count_track: assert property (@(posedge CLK_SYS_I) disable iff (SRST_I)
    wr_ok && !rd_ok |=> cnt_reg == $past(cnt_reg) + CNT_ONE) else $error("count wrong");
  a_cfg_frozen: assert property (@(posedge CLK_SYS_I) disable iff (SRST_I)
    $stable(cfg_reg)) else $error("pin function changed after reset");
  a_bus_enable: assert property (@(posedge CLK_SYS_I) disable iff (SRST_I)
    READ_DATA_BUS_OE_O == OUTPUT_EN_I) else $error("bus enable wrong");
endmodule

/* File: tb/ffx_producer.sv */
// ffx_producer: write-side producer model streaming a counting pattern
// assumes a write is taken on the rising edge while full_n_i is high
`timescale 1ns/1ps
module ffx_producer
  import ffx_pkg::*;
(
  // clock and command
  input  wire logic              clk_i,
  input  wire logic              start_i,
  input  wire logic [CNT_W-1:0]  num_i,
  input  wire logic              full_n_i,
  // write port
  output logic                   we_o,
  output logic [DATA_W-1:0]      wd_o,
  output logic                   busy_o
);
  logic [CNT_W-1:0]  left = 11'h000;   // words still to send
  logic [DATA_W-1:0] idx  = 18'h00000; // words sent so far
  initial we_o = 1'b0;
  initial wd_o = 18'h00100;
  // a word counts only when the fifo had room at that edge
  always @(posedge clk_i) begin
    if (start_i) begin
      left <= num_i;
    end else if (we_o && full_n_i) begin
      left <= left - 11'h001;
      idx  <= idx + 18'h00001;
    end
  end
  // drive on the falling edge, away from the sampling edge
  always @(negedge clk_i) begin
    we_o = (left != 11'h000);
    wd_o = idx + 18'h00100;
  end
  assign busy_o = (left != 11'h000);
endmodule

/* File: tb/ffx_top_tb.sv */
// ffx_top_tb: directed bench for flags, expansion pins and read bus
// assumes the producer model owns the write port, the bench the rest
`timescale 1ns/1ps
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin errors++; \
  $display("BAD t=%0t got=%h exp=%h", $time, (a), (e)); end end
module ffx_top_tb import ffx_pkg::*; ();
  logic clk = 1'b0, srst = 1'b1, rd_en = 1'b0, oe = 1'b0;   // clock, reset, read side
  logic mode_n = 1'b1, write_expansion_in = 1'b0, read_expansion_in = 1'b0;               // straps
  logic [1:0] hf_sel = 2'b11;                                 // half-full timing
  logic ae_sel = 1'b1, ae_ld = 1'b0, start = 1'b0;            // control bits
  logic [CNT_W-1:0] ae_ofs = 11'h000, num = 11'h000, occ;     // offset, burst, count
  logic we, busy, chk_enh = 1'b0, last_e = 1'b0;              // producer and monitor
  logic empty_n, ae_n, hf_n, full_n, write_expansion_out, read_expansion_out, boe;           // flags and pins
  logic [DATA_W-1:0] wd, rdat;                                // data paths
  int errors = 0, cmp_count = 0, rcount = 0, wcount = 0, wxo_cnt = 0, rxo_cnt = 0;
  always #2.5 clk = ~clk;
  ffx_producer prod_u (.clk_i(clk), .start_i(start), .num_i(num), .full_n_i(full_n),
    .we_o(we), .wd_o(wd), .busy_o(busy));
  ffx_top dut_u (.CLK_SYS_I(clk), .SRST_I(srst), .WRITE_EN_I(we), .WRITE_DATA_I(wd),
    .READ_EN_I(rd_en), .OUTPUT_EN_I(oe), .ENHANCED_MODE_SELECT_N_I(mode_n),
    .WRITE_EXPANSION_IN_I(write_expansion_in), .READ_EXPANSION_IN_I(read_expansion_in), .HF_SYNC_SEL_I(hf_sel),
    .AE_SYNC_SEL_I(ae_sel), .AE_OFS_LOAD_I(ae_ld), .AE_OFS_I(ae_ofs),
    .EMPTY_N_O(empty_n), .ALMOST_EMPTY_N_O(ae_n), .HALF_FULL_N_O(hf_n),
    .FULL_N_O(full_n), .WRITE_EXPANSION_OUT_O(write_expansion_out), .READ_EXPANSION_OUT_O(read_expansion_out),
    .READ_DATA_BUS_O(rdat), .READ_DATA_BUS_OE_O(boe), .OCCUPANCY_O(occ));
  // verdict and end of run
  task automatic conclude();
    if (errors == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic tick(int n);
    repeat (n) @(negedge clk);
  endtask
  // straps held through a six-cycle reset; stored words are lost
  task automatic rst(logic m, logic x);
    mode_n = m;
    write_expansion_in = x;
    srst = 1'b1;
    tick(6);
    srst = 1'b0;
    rcount = wcount;
  endtask
  // burst of n words from the producer, bounded wait
  task automatic wr(int n);
    int k;
    num = CNT_W'(n);
    start = 1'b1;
    tick(1);
    start = 1'b0;
    for (k = 0; k < 3000 && busy; k++) tick(1);
    if (busy) begin
      errors++;
      conclude();
    end
    wcount += n;
  endtask
  // back-to-back reads, data due one cycle after each
  task automatic rd(int n);
    repeat (n) begin
      rd_en = 1'b1;
      tick(1);
      `CHK(rdat, DATA_W'(rcount) + 18'h00100)
      rcount++;
    end
    rd_en = 1'b0;
  endtask
  // delayed empty copy watched every cycle while enabled
  always @(negedge clk) begin
    if (chk_enh) `CHK(read_expansion_out, last_e)
    last_e = empty_n;
  end
  // expansion pulse counters, cleared by reset
  always @(posedge clk) begin
    if (srst) begin
      wxo_cnt = 0;
      rxo_cnt = 0;
    end else begin
      wxo_cnt += int'(write_expansion_out === 1'b1);
      rxo_cnt += int'(read_expansion_out === 1'b1);
    end
  end
  initial begin
    tick(1);
    rst(1'b1, 1'b0);
    `CHK({empty_n, ae_n, hf_n, occ}, {3'b001, 11'h000})
    rd_en = 1'b1;
    tick(1);
    rd_en = 1'b0;
    `CHK(occ, 11'h000)
    wr(127);
    `CHK(ae_n, 1'b0)
    wr(1);
    `CHK({ae_n, occ}, {1'b1, 11'h080})
    wr(384);
    `CHK(hf_n, 1'b1)
    wr(1);
    `CHK({hf_n, write_expansion_out}, 2'b00)
    oe = 1'b1;
    rd(513);
    `CHK({boe, empty_n, occ, read_expansion_out}, {2'b10, 11'h000, 1'b0})
    oe = 1'b0;
    tick(1);
    `CHK(boe, 1'b0)
    rd_en = 1'b1;
    tick(1);
    rd_en = 1'b0;
    `CHK(rdat, 18'h00300)
    rst(1'b1, 1'b0);
    ae_ld = 1'b1;
    ae_ofs = 11'h003;
    tick(1);
    ae_ld = 1'b0;
    wr(3);
    `CHK(ae_n, 1'b0)
    wr(1);
    `CHK(ae_n, 1'b1)
    rd(4);
    rst(1'b1, 1'b1);
    wr(1024);
    tick(2);
    `CHK({full_n, wxo_cnt == 1}, 2'b01)
    rd(1024);
    tick(2);
    `CHK({empty_n, rxo_cnt == 1}, 2'b01)
    read_expansion_in = 1'b1;
    rst(1'b1, 1'b0);
    `CHK({write_expansion_out, read_expansion_out, hf_n}, 3'b001)
    read_expansion_in = 1'b0;
    hf_sel = 2'b01;
    ae_sel = 1'b1;
    rst(1'b0, 1'b0);
    tick(2);
    chk_enh = 1'b1;
    wr(2);
    tick(2);
    `CHK({empty_n, ae_n, hf_n}, 3'b101)
    wr(126);
    `CHK(ae_n, 1'b0)
    tick(1);
    `CHK(ae_n, 1'b1)
    hf_sel = 2'b11;
    wr(385);
    `CHK(hf_n, 1'b1)
    tick(1);
    `CHK(hf_n, 1'b0)
    rd(513);
    tick(2);
    chk_enh = 1'b0;
    conclude();
  end
endmodule
